/* design/doze_pkg.sv */
// Constants, register map and power-mode types for the downshift sequencer.
// Assumes a 40 MHz system clock and a byte-wide register map on the serial port.
package doze_pkg;

  // ==========================================================
  // Clock and timing
  localparam int CLK_FREQ_KHZ = 40000; // System clock, kHz
  localparam int POS_PERIOD_US = 4000; // Run-mode position period, us
  localparam int SLOW_PERIOD_US = 10000; // Slow clock period, us
  localparam int POS_PERIOD_CYC = POS_PERIOD_US * CLK_FREQ_KHZ / 1000;
  localparam int SLOW_PERIOD_CYC = SLOW_PERIOD_US * CLK_FREQ_KHZ / 1000;

  // ==========================================================
  // Register offsets (7-bit serial address)
  localparam logic [6:0] OFS_RUN_TO_DOZE1 = 7'h0e;
  localparam logic [6:0] OFS_DOZE1_INTERVAL = 7'h0f;
  localparam logic [6:0] OFS_DOZE1_TO_DOZE2 = 7'h10;
  localparam logic [6:0] OFS_DOZE2_INTERVAL = 7'h11;
  localparam logic [6:0] OFS_DOZE2_TO_DOZE3 = 7'h12;
  localparam logic [6:0] OFS_DOZE3_INTERVAL = 7'h13;
  localparam logic [6:0] OFS_MODE_OVERRIDE = 7'h22;
  localparam logic [6:0] OFS_CHIP_RESET = 7'h3a;

  // Storage slots
  localparam int NUM_REGS = 8;
  localparam logic [2:0] IDX_RUN_TO_DOZE1 = 3'h0;
  localparam logic [2:0] IDX_DOZE1_INTERVAL = 3'h1;
  localparam logic [2:0] IDX_DOZE1_TO_DOZE2 = 3'h2;
  localparam logic [2:0] IDX_DOZE2_INTERVAL = 3'h3;
  localparam logic [2:0] IDX_DOZE2_TO_DOZE3 = 3'h4;
  localparam logic [2:0] IDX_DOZE3_INTERVAL = 3'h5;
  localparam logic [2:0] IDX_MODE_OVERRIDE = 3'h6;
  localparam logic [2:0] IDX_CHIP_RESET = 3'h7;

  // Reset values, slot 7 first down to slot 0
  localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {8'h00, 8'h00, 8'h31, 8'h2f, 8'h09, 8'h1f, 8'h01, 8'h08};

  // ==========================================================
  // Fields and keys
  localparam logic [7:0] CHIP_RESET_KEY = 8'h5a;
  localparam int FORCE_LSB = 4;
  localparam int FORCE_MSB = 6;
  localparam int RUN_SHIFT_LSH = 3; // Times 8
  localparam int DOZE1_SHIFT_LSH = 4; // Times 16
  localparam int DOZE2_SHIFT_LSH = 7; // Times 128
  localparam int SHIFT_W = 15; // 8-bit count times up to 128

  // Forced mode codes
  localparam logic [2:0] FORCE_AUTO = 3'h0;
  localparam logic [2:0] FORCE_DOZE1 = 3'h1;
  localparam logic [2:0] FORCE_DOZE2 = 3'h2;
  localparam logic [2:0] FORCE_DOZE3 = 3'h3;
  localparam logic [2:0] FORCE_RUN1 = 3'h4;
  localparam logic [2:0] FORCE_RUN2 = 3'h5;
  localparam logic [2:0] FORCE_IDLE = 3'h6;

  // ==========================================================
  // Serial framing
  localparam logic [4:0] SER_ADDR_BITS = 5'h08;
  localparam logic [4:0] SER_FRAME_BITS = 5'h10;
  localparam int SER_WRITE_BIT = 15; // First bit: 1 means write

  // Operating modes
  typedef enum logic [2:0] {
    MODE_RUN1,
    MODE_RUN2,
    MODE_IDLE,
    MODE_DOZE1,
    MODE_DOZE2,
    MODE_DOZE3
  } power_mode_e;

  // Address to slot: bit 3 flags a mapped address
  function automatic logic [3:0] reg_slot(input logic [6:0] addr);
    case (addr)
      OFS_RUN_TO_DOZE1: reg_slot = {1'b1, IDX_RUN_TO_DOZE1};
      OFS_DOZE1_INTERVAL: reg_slot = {1'b1, IDX_DOZE1_INTERVAL};
      OFS_DOZE1_TO_DOZE2: reg_slot = {1'b1, IDX_DOZE1_TO_DOZE2};
      OFS_DOZE2_INTERVAL: reg_slot = {1'b1, IDX_DOZE2_INTERVAL};
      OFS_DOZE2_TO_DOZE3: reg_slot = {1'b1, IDX_DOZE2_TO_DOZE3};
      OFS_DOZE3_INTERVAL: reg_slot = {1'b1, IDX_DOZE3_INTERVAL};
      OFS_MODE_OVERRIDE: reg_slot = {1'b1, IDX_MODE_OVERRIDE};
      OFS_CHIP_RESET: reg_slot = {1'b1, IDX_CHIP_RESET};
      default: reg_slot = 4'h0;
    endcase
  endfunction

endpackage

/* design/regs_if.sv */
// Carrier between the sequencer and its register store.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface regs_if;
  logic wr_en; // Write strobe, one cycle
  logic [2:0] wr_idx; // Slot written
  logic [7:0] wr_data; // Byte written
  logic rd_en; // Read strobe, one cycle
  logic [2:0] rd_idx; // Slot read
  logic [7:0] rd_data; // Registered read byte
  logic [doze_pkg::NUM_REGS-1:0][7:0] value; // Live register contents
  logic clear; // Reload reset values

  modport ctrl (output wr_en, wr_idx, wr_data, rd_en, rd_idx, clear, input rd_data, value);
  modport store (input wr_en, wr_idx, wr_data, rd_en, rd_idx, clear, output rd_data, value);
endinterface

/* design/doze_reg_store.sv */
// Eight byte register store with registered read data.
// Assumes slot 7 is the write-only chip reset slot and reads as zero.
`timescale 1ns/1ps
module doze_reg_store (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Register access
  regs_if.store regs
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [doze_pkg::NUM_REGS-1:0][7:0] mem; // Contents
    logic [7:0] rd_data; // Read register
  } store_s;

  store_s st_ff;
  store_s nxt_st;

  // Write, read and reload
  always_comb begin
    nxt_st = st_ff;
    if (regs.clear) begin
      nxt_st.mem = doze_pkg::REG_RESET;
    end else if (regs.wr_en && regs.wr_idx != doze_pkg::IDX_CHIP_RESET) begin
      nxt_st.mem[regs.wr_idx] = regs.wr_data;
    end
    if (regs.rd_en) begin
      // Write-only slot never echoes the key
      nxt_st.rd_data = (regs.rd_idx == doze_pkg::IDX_CHIP_RESET) ? 8'h00 : st_ff.mem[regs.rd_idx];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      st_ff <= '{mem: doze_pkg::REG_RESET, rd_data: 8'h00};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign regs.rd_data = st_ff.rd_data;
  assign regs.value = st_ff.mem;

endmodule

/* design/tick_divider.sv */
// Free-running divider giving a one-cycle tick every CYCLES clocks.
// Assumes clear_i restarts the count from zero.
`timescale 1ns/1ps
module tick_divider #(
  parameter int CYCLES = 4
) (
  // Clock and control
  input wire logic sys_clk_i,
  input wire logic clear_i,
  // Tick out
  output logic tick_o
);

  initial begin
    if (CYCLES < 2 || CYCLES > 2**24) $error("tick_divider: CYCLES out of range");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [23:0] cnt; // Cycles into the period
    logic tick; // Period end
  } div_s;

  div_s st_ff;
  div_s nxt_st;

  // Count and wrap
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == 24'(CYCLES - 1)) begin
      nxt_st.cnt = 24'h000000;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 24'h000001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (clear_i) begin
      st_ff <= '{cnt: 24'h000000, tick: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick_o = st_ff.tick;

endmodule

/* design/doze_sequencer.sv */
// Power-saving downshift sequencer with its serial register port.
// Assumes SCLK and SDIO are synchronous to sys_clk_i and SCLK half periods last 3 clocks or more.
// Behaviour
// - Run holds for run count times 8 position periods
// - Doze frame is (interval plus one) slow periods
// - Doze1 to doze2 after count times interval times 16
// - Doze2 to doze3 after count times interval times 128
// - Override field 6:4 pins the operating mode
// - Writing 0x5a to reset register resets chip
`timescale 1ns/1ps
module doze_sequencer #(
  parameter int POS_PERIOD_CYC = doze_pkg::POS_PERIOD_CYC,
  parameter int SLOW_PERIOD_CYC = doze_pkg::SLOW_PERIOD_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // Two-wire serial port
  input wire logic sclk_i,
  input wire logic sdio_i,
  output logic sdio_o,
  output logic sdio_oe_o,
  // Sensor side
  input wire logic motion_i,
  output logic [2:0] power_mode_o,
  output logic frame_strobe_o,
  output logic chip_reset_o
);

  initial begin
    if (POS_PERIOD_CYC < 2 || SLOW_PERIOD_CYC < 2) $error("doze_sequencer: periods too short");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic sclk_prev; // Last SCLK sample
    logic [4:0] bit_cnt; // Bits seen in this frame
    logic [15:0] shift_in; // Address and data bits in
    logic [7:0] shift_out; // Read byte going out
    logic rd_wait; // Read data due from store
    logic rd_load; // Load read byte next cycle
    logic rd_frame; // Read frame in progress
    logic sdio; // Driven data bit
    logic sdio_oe; // Drive enable
    logic soft_rst; // Chip reset pulse
    doze_pkg::power_mode_e mode; // Operating mode
    logic [2:0] force_seen; // Override applied last
    logic [7:0] slow_cnt; // Slow ticks in this doze frame
    logic [doze_pkg::SHIFT_W-1:0] frame_cnt; // Quiet frames in this mode
    logic frame; // Frame end
  } seq_s;

  seq_s st_ff;
  seq_s nxt_st;
  logic clear_all; // Hard or chip reset
  logic pos_tick; // Position period end
  logic slow_tick; // Slow clock period end
  logic [3:0] slot; // Decoded address
  logic [3:0] rd_slot; // Decoded address of a read
  logic [2:0] force_code; // Override field
  logic [doze_pkg::SHIFT_W-1:0] shift_limit; // Frames before downshift
  logic frame_end; // Current frame completes
  logic [7:0] interval; // Doze interval register

  regs_if regs ();

  // All assertions below run on the system clock and rest in hard reset
  default clocking cb_sys @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Sub-blocks
  doze_reg_store u_store (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .regs(regs.store)
  );

  tick_divider #(.CYCLES(POS_PERIOD_CYC)) u_pos_div (
    .sys_clk_i(sys_clk_i),
    .clear_i(clear_all),
    .tick_o(pos_tick)
  );

  tick_divider #(.CYCLES(SLOW_PERIOD_CYC)) u_slow_div (
    .sys_clk_i(sys_clk_i),
    .clear_i(clear_all),
    .tick_o(slow_tick)
  );

  // Chip reset clears everything the next cycle
  assign clear_all = rst_i | st_ff.soft_rst;
  // At the last write bit the address sits just below the write flag
  assign slot = doze_pkg::reg_slot(st_ff.shift_in[13:7]);
  assign rd_slot = doze_pkg::reg_slot({st_ff.shift_in[5:0], sdio_i});
  assign force_code = regs.value[doze_pkg::IDX_MODE_OVERRIDE][doze_pkg::FORCE_MSB:doze_pkg::FORCE_LSB];

  // ==========================================================
  // Frame timing per mode
  always_comb begin
    interval = 8'h00;
    shift_limit = '0;
    case (st_ff.mode)
      doze_pkg::MODE_DOZE1: begin
        interval = regs.value[doze_pkg::IDX_DOZE1_INTERVAL];
        shift_limit = doze_pkg::SHIFT_W'(regs.value[doze_pkg::IDX_DOZE1_TO_DOZE2]);
        shift_limit = shift_limit << doze_pkg::DOZE1_SHIFT_LSH;
      end
      doze_pkg::MODE_DOZE2: begin
        interval = regs.value[doze_pkg::IDX_DOZE2_INTERVAL];
        shift_limit = doze_pkg::SHIFT_W'(regs.value[doze_pkg::IDX_DOZE2_TO_DOZE3]);
        shift_limit = shift_limit << doze_pkg::DOZE2_SHIFT_LSH;
      end
      doze_pkg::MODE_DOZE3: begin
        interval = regs.value[doze_pkg::IDX_DOZE3_INTERVAL];
      end
      doze_pkg::MODE_RUN1: begin
        shift_limit = doze_pkg::SHIFT_W'(regs.value[doze_pkg::IDX_RUN_TO_DOZE1]);
        shift_limit = shift_limit << doze_pkg::RUN_SHIFT_LSH;
      end
      default: begin
        shift_limit = '0;
      end
    endcase
  end

  // Run frames follow the position period, doze frames count slow ticks
  assign frame_end = (st_ff.mode inside {doze_pkg::MODE_DOZE1, doze_pkg::MODE_DOZE2, doze_pkg::MODE_DOZE3})
                     ? (slow_tick && st_ff.slow_cnt == interval) : pos_tick;

  // Override code to the mode it pins; auto lands in run1 too
  function automatic doze_pkg::power_mode_e force_mode(input logic [2:0] code);
    case (code)
      doze_pkg::FORCE_DOZE1: force_mode = doze_pkg::MODE_DOZE1;
      doze_pkg::FORCE_DOZE2: force_mode = doze_pkg::MODE_DOZE2;
      doze_pkg::FORCE_DOZE3: force_mode = doze_pkg::MODE_DOZE3;
      doze_pkg::FORCE_RUN1: force_mode = doze_pkg::MODE_RUN1;
      doze_pkg::FORCE_RUN2: force_mode = doze_pkg::MODE_RUN2;
      doze_pkg::FORCE_IDLE: force_mode = doze_pkg::MODE_IDLE;
      default: force_mode = doze_pkg::MODE_RUN1;
    endcase
  endfunction

  // ==========================================================
  // Next state: serial port, then power modes
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sclk_prev = sclk_i;
    nxt_st.soft_rst = 1'b0;
    nxt_st.frame = 1'b0;
    nxt_st.rd_load = 1'b0;
    regs.wr_en = 1'b0;
    regs.wr_idx = slot[2:0];
    regs.wr_data = {st_ff.shift_in[6:0], sdio_i};
    regs.rd_en = 1'b0;
    regs.rd_idx = slot[2:0];
    regs.clear = st_ff.soft_rst;

    // Rising SCLK: sample a bit
    if (sclk_i && !st_ff.sclk_prev) begin
      nxt_st.shift_in = {st_ff.shift_in[14:0], sdio_i};
      nxt_st.bit_cnt = st_ff.bit_cnt + 5'h01;
      if (st_ff.bit_cnt == doze_pkg::SER_ADDR_BITS - 5'h01 && !st_ff.shift_in[6]) begin
        // Address complete on a read: fetch the byte
        regs.rd_en = 1'b1;
        // Unmapped addresses fetch the write-only slot, which reads as zero
        regs.rd_idx = rd_slot[3] ? rd_slot[2:0] : doze_pkg::IDX_CHIP_RESET;
        nxt_st.rd_wait = 1'b1;
        nxt_st.rd_frame = 1'b1;
      end
      if (st_ff.bit_cnt == doze_pkg::SER_FRAME_BITS - 5'h01) begin
        nxt_st.bit_cnt = 5'h00;
        nxt_st.sdio_oe = 1'b0;
        nxt_st.rd_frame = 1'b0;
        if (st_ff.shift_in[doze_pkg::SER_WRITE_BIT - 1] && slot[3]) begin
          regs.wr_en = 1'b1;
          // Only the key triggers; other values are dropped
          if (slot[2:0] == doze_pkg::IDX_CHIP_RESET && regs.wr_data == doze_pkg::CHIP_RESET_KEY) begin
            nxt_st.soft_rst = 1'b1;
          end
        end
      end
    end

    // Read byte arrives one cycle after the fetch
    if (st_ff.rd_wait) begin
      nxt_st.rd_wait = 1'b0;
      nxt_st.rd_load = 1'b1;
    end
    if (st_ff.rd_load) begin
      nxt_st.shift_out = regs.rd_data;
    end

    // Falling SCLK in the data phase of a read: drive next bit, MSB first
    if (!sclk_i && st_ff.sclk_prev && st_ff.rd_frame && st_ff.bit_cnt >= doze_pkg::SER_ADDR_BITS) begin
      nxt_st.sdio = st_ff.shift_out[7];
      nxt_st.shift_out = {st_ff.shift_out[6:0], 1'b0};
      nxt_st.sdio_oe = 1'b1;
    end

    // Power mode sequencing
    nxt_st.force_seen = force_code;
    if (force_code != st_ff.force_seen) begin
      // Override changed: jump and restart the timers
      nxt_st.slow_cnt = 8'h00;
      nxt_st.frame_cnt = '0;
      nxt_st.mode = force_mode(force_code);
    end else if (force_code == doze_pkg::FORCE_AUTO && motion_i) begin
      // Motion wakes to run and restarts the downshift count
      nxt_st.mode = doze_pkg::MODE_RUN1;
      nxt_st.frame_cnt = '0;
      if (st_ff.mode != doze_pkg::MODE_RUN1) begin
        nxt_st.slow_cnt = 8'h00;
      end
    end else begin
      if (slow_tick) begin
        nxt_st.slow_cnt = (st_ff.slow_cnt == interval) ? 8'h00 : st_ff.slow_cnt + 8'h01;
      end
      if (frame_end) begin
        nxt_st.frame = 1'b1;
        // Downshift only in automatic mode and with a nonzero count
        if (force_code == doze_pkg::FORCE_AUTO && shift_limit != '0
            && st_ff.frame_cnt == shift_limit - 1'b1) begin
          nxt_st.frame_cnt = '0;
          nxt_st.slow_cnt = 8'h00;
          case (st_ff.mode)
            doze_pkg::MODE_RUN1: nxt_st.mode = doze_pkg::MODE_DOZE1;
            doze_pkg::MODE_DOZE1: nxt_st.mode = doze_pkg::MODE_DOZE2;
            doze_pkg::MODE_DOZE2: nxt_st.mode = doze_pkg::MODE_DOZE3;
            default: nxt_st.mode = st_ff.mode;
          endcase
        end else begin
          nxt_st.frame_cnt = st_ff.frame_cnt + 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Assertions
  // Automatic operation with no override change, motion or chip reset
  sequence s_auto_quiet;
    force_code == doze_pkg::FORCE_AUTO && st_ff.force_seen == doze_pkg::FORCE_AUTO
    && !motion_i && !st_ff.soft_rst;
  endsequence

  // Last frame of a nonzero downshift count ends now
  sequence s_count_done;
    frame_end && shift_limit != '0 && st_ff.frame_cnt == shift_limit - 1'b1;
  endsequence

  // A finished write that carries the reset key
  sequence s_key_write;
    regs.wr_en && regs.wr_idx == doze_pkg::IDX_CHIP_RESET && regs.wr_data == doze_pkg::CHIP_RESET_KEY;
  endsequence

  a_run_shift: assert property (
    s_auto_quiet ##0 (st_ff.mode == doze_pkg::MODE_RUN1) ##0 s_count_done |=> st_ff.mode == doze_pkg::MODE_DOZE1)
    else $error("run did not step to doze1");

  a_doze1_shift: assert property (
    s_auto_quiet ##0 (st_ff.mode == doze_pkg::MODE_DOZE1) ##0 s_count_done |=> st_ff.mode == doze_pkg::MODE_DOZE2)
    else $error("doze1 did not step to doze2");

  a_doze2_shift: assert property (
    s_auto_quiet ##0 (st_ff.mode == doze_pkg::MODE_DOZE2) ##0 s_count_done |=> st_ff.mode == doze_pkg::MODE_DOZE3)
    else $error("doze2 did not step to doze3");

  // Doze frames end only on the slow tick that fills the interval
  a_doze_frame_gate: assert property (
    st_ff.mode inside {doze_pkg::MODE_DOZE1, doze_pkg::MODE_DOZE2, doze_pkg::MODE_DOZE3}
    && st_ff.slow_cnt != interval |=> !st_ff.frame) else $error("doze frame ended early");

  a_force_pins_mode: assert property (
    force_code != doze_pkg::FORCE_AUTO && force_code == st_ff.force_seen |-> st_ff.mode == force_mode(force_code))
    else $error("override did not pin the mode");

  a_motion_wakes: assert property (
    force_code == doze_pkg::FORCE_AUTO && st_ff.force_seen == doze_pkg::FORCE_AUTO && motion_i
    |=> st_ff.mode == doze_pkg::MODE_RUN1 && st_ff.frame_cnt == '0) else $error("motion did not wake to run");

  a_key_resets: assert property (
    s_key_write |=> st_ff.soft_rst ##1 (st_ff.mode == doze_pkg::MODE_RUN1 && !st_ff.soft_rst && st_ff.bit_cnt == 5'h00))
    else $error("reset key did not reset the chip");

  a_bad_key_ignored: assert property (
    regs.wr_en && regs.wr_idx == doze_pkg::IDX_CHIP_RESET && regs.wr_data != doze_pkg::CHIP_RESET_KEY
    |=> !st_ff.soft_rst) else $error("wrong key reset the chip");

  always_ff @(posedge sys_clk_i) begin
    if (clear_all) begin
      // SCLK idles high, so a low start value would fake a first edge
      st_ff <= '{sclk_prev: 1'b1, bit_cnt: 5'h00, shift_in: 16'h0000, shift_out: 8'h00, rd_wait: 1'b0,
                 rd_load: 1'b0, rd_frame: 1'b0, sdio: 1'b0, sdio_oe: 1'b0, soft_rst: 1'b0,
                 mode: doze_pkg::MODE_RUN1,
                 force_seen: doze_pkg::FORCE_AUTO, slow_cnt: 8'h00, frame_cnt: '0, frame: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sdio_o = st_ff.sdio;
  assign sdio_oe_o = st_ff.sdio_oe;
  assign power_mode_o = st_ff.mode;
  assign frame_strobe_o = st_ff.frame;
  assign chip_reset_o = st_ff.soft_rst;

endmodule

/* test/ser_host.sv */
// Model of the mouse controller that drives the two-wire serial port.
// Assumes SCLK idles high, the device samples on SCLK rise and bits go MSB first.
`timescale 1ns/1ps
module ser_host #(
  parameter int HALF = 4 // SCLK half period, clocks
) (
  // Clock and resolved line
  input wire logic sys_clk_i,
  input wire logic sdio_i,
  // Pins driven by the controller
  output logic sclk_o,
  output logic sdio_o,
  output logic sdio_oe_o
);
  // ==========================================
  // Idle pins
  initial begin
    sclk_o = 1'b1;
    sdio_o = 1'b0;
    sdio_oe_o = 1'b0;
  end

  // Whole clocks, then settle just after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask

  // ==========================================
  // One bit: data set while SCLK is low, line sampled at the rise
  task automatic bit_cycle(input logic d, input logic drive, output logic q);
    sclk_o = 1'b0;
    sdio_oe_o = drive;
    sdio_o = d;
    tick(HALF);
    q = sdio_i;
    sclk_o = 1'b1;
    tick(HALF);
  endtask

  // Write frame: write flag, 7-bit address, data byte
  task automatic wr_reg(input logic [6:0] addr, input logic [7:0] data);
    logic [15:0] f;
    logic q;
    f = {1'b1, addr, data};
    tick(1);
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(f[i], 1'b1, q);
    end
    sdio_oe_o = 1'b0;
    tick(HALF);
  endtask

  // Read frame; a long turnaround gives the device time to take the line
  task automatic rd_reg(input logic [6:0] addr, output logic [7:0] data);
    logic [7:0] a;
    logic q;
    a = {1'b0, addr};
    tick(1);
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(a[i], 1'b1, q);
    end
    sdio_oe_o = 1'b0;
    tick(4 * HALF);
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b0, 1'b0, q);
      data[i] = q;
    end
    tick(HALF);
  endtask

  // ==========================================
  // Timing writes: legal values only, bracketed by a pinned run mode
  task automatic wr_timing(input logic [6:0] addr, input logic [7:0] data);
    logic [7:0] v;
    v = data;
    if (v == 8'h00) begin
      v = 8'h01;
    end
    if (addr[0] && v > 8'hfd) begin
      v = 8'hfd;
    end
    wr_reg(7'h22, 8'h40);
    wr_reg(addr, v);
    wr_reg(7'h22, 8'h00);
  endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench for the downshift sequencer and its register port.
// Assumes shortened periods: position 4 clocks, slow clock 2 clocks.
`timescale 1ns/1ps
module tb_top;
  // ==========================================
  // Settings and wires
  localparam int POS = 4; // Position period, clocks
  localparam int SLOW = 2; // Slow period, clocks
  logic sys_clk = 1'b0;
  logic rst;
  logic motion;
  logic sclk, host_d, host_oe, dev_d, dev_oe;
  logic last_line = 1'b0; // Last line level, for a floating line
  logic sdio_line;
  logic [2:0] power_mode;
  logic frame_strobe, chip_reset;
  int miscompares = 0;
  int total_checks = 0;
  int reset_pulses = 0; // Cycles with the chip reset output high

  always #12.5 sys_clk = ~sys_clk;

  // No pull on the line: a released line toggles so stale data never passes
  assign sdio_line = dev_oe ? dev_d : (host_oe ? host_d : ~last_line);
  always @(posedge sys_clk) last_line <= sdio_line;

  // The reset pulse may land inside a frame, so it is counted here
  always @(posedge sys_clk) begin
    if (chip_reset === 1'b1) begin
      reset_pulses++;
    end
  end

  doze_sequencer #(.POS_PERIOD_CYC(POS), .SLOW_PERIOD_CYC(SLOW)) dut (
    .sys_clk_i(sys_clk), .rst_i(rst), .sclk_i(sclk), .sdio_i(sdio_line), .sdio_o(dev_d),
    .sdio_oe_o(dev_oe), .motion_i(motion), .power_mode_o(power_mode),
    .frame_strobe_o(frame_strobe), .chip_reset_o(chip_reset));

  ser_host #(.HALF(4)) host (
    .sys_clk_i(sys_clk), .sdio_i(sdio_line), .sclk_o(sclk), .sdio_o(host_d), .sdio_oe_o(host_oe));

  // ==========================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask

  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got 0x%0h expected 0x%0h", $time, got, exp);
    end
  endtask

  // A cycle count must fall inside a window
  task automatic chk_span(input int n, input int lo, input int hi);
    total_checks++;
    if (n < lo || n > hi) begin
      miscompares++;
      $display("Error at %0t: got 0x%0h expected 0x%0h to 0x%0h", $time, n, lo, hi);
    end
  endtask

  // Cycles until a mode shows; a stuck mode ends the run
  task automatic wait_mode(input logic [2:0] m, output int n);
    n = 0;
    while (power_mode !== m) begin
      tick(1);
      n++;
      if (n > 5000) begin
        chk(power_mode, m);
        stop_test();
      end
    end
  endtask

  // Spacing of two frame strobes; a strobe showing at the start is skipped
  task automatic frame_gap(output int n);
    tick(1);
    n = 0;
    while (frame_strobe !== 1'b1 && n < 1000) begin
      tick(1);
      n++;
    end
    n = 0;
    do begin
      tick(1);
      n++;
    end while (frame_strobe !== 1'b1 && n < 1000);
  endtask

  // ==========================================
  // Scenarios
  task automatic sc_run_hold();
    int n;
    wait_mode(doze_pkg::MODE_DOZE1, n);
    chk_span(n, 256 - POS, 256 + POS + 8);
    frame_gap(n);
    chk_span(n, 2 * SLOW, 2 * SLOW);
  endtask

  // Reset values, write-only slot and an unmapped address
  task automatic sc_reg_defaults();
    logic [6:0] ofs [9] = '{7'h0e, 7'h0f, 7'h10, 7'h11, 7'h12, 7'h13, 7'h22, 7'h3a, 7'h20};
    logic [7:0] rv [9] = '{8'h08, 8'h01, 8'h1f, 8'h09, 8'h2f, 8'h31, 8'h00, 8'h00, 8'h00};
    logic [7:0] d;
    for (int i = 0; i < 9; i++) begin
      host.rd_reg(ofs[i], d);
      chk(d, rv[i]);
    end
  endtask

  task automatic sc_downshift();
    int n;
    logic [7:0] d;
    host.wr_timing(7'h10, 8'h02);
    host.wr_timing(7'h11, 8'h01);
    host.wr_timing(7'h12, 8'h01);
    host.wr_timing(7'h13, 8'h02);
    host.rd_reg(7'h10, d);
    chk(d, 8'h02);
    // Steady motion keeps run well past the run hold time
    motion = 1'b1;
    tick(400);
    chk(power_mode, doze_pkg::MODE_RUN1);
    motion = 1'b0;
    wait_mode(doze_pkg::MODE_DOZE1, n);
    chk_span(n, 256 - POS, 256 + POS + 8);
    wait_mode(doze_pkg::MODE_DOZE2, n);
    chk_span(n, 2 * 4 * 16 - 4, 2 * 4 * 16 + 12);
    wait_mode(doze_pkg::MODE_DOZE3, n);
    chk_span(n, 4 * 128 - 4, 4 * 128 + 12);
    frame_gap(n);
    chk_span(n, 3 * SLOW, 3 * SLOW);
    motion = 1'b1;
    tick(1);
    motion = 1'b0;
    wait_mode(doze_pkg::MODE_RUN1, n);
    chk_span(n, 0, 8);
  endtask

  // Every override code pins its mode; code 0 hands back control
  task automatic sc_force();
    logic [2:0] fm [7] = '{doze_pkg::MODE_RUN1, doze_pkg::MODE_DOZE1, doze_pkg::MODE_DOZE2,
      doze_pkg::MODE_DOZE3, doze_pkg::MODE_RUN1, doze_pkg::MODE_RUN2, doze_pkg::MODE_IDLE};
    int n;
    for (int c = 1; c < 7; c++) begin
      host.wr_reg(7'h22, {1'b0, 3'(c), 4'h0});
      tick(8);
      chk(power_mode, fm[c]);
    end
    host.wr_reg(7'h22, 8'h00);
    wait_mode(doze_pkg::MODE_DOZE1, n);
    chk_span(n, 1, 256 + POS + 8);
  endtask

  task automatic sc_chip_reset();
    int p;
    logic [7:0] d;
    p = reset_pulses;
    host.wr_reg(7'h3a, 8'h33);
    tick(16);
    chk_span(reset_pulses - p, 0, 0);
    host.rd_reg(7'h10, d);
    chk(d, 8'h02);
    host.wr_reg(7'h3a, 8'h5a);
    tick(16);
    chk_span(reset_pulses - p, 1, 64);
    host.rd_reg(7'h10, d);
    chk(d, 8'h1f);
  endtask

  // ==========================================
  // Main sequence and hang guard
  initial begin
    rst = 1'b1;
    motion = 1'b0;
    tick(4);
    rst = 1'b0;
    sc_run_hold();
    sc_reg_defaults();
    sc_downshift();
    sc_force();
    sc_chip_reset();
    stop_test();
  end

  initial begin
    repeat (100000) @(posedge sys_clk);
    chk(16'h0001, 16'h0000);
    stop_test();
  end
endmodule
